// >>> src/host_port_params.svh
// Purpose: named constants of the multiplexed host bus port
// Assumes: ref_clk at 250 MHz
// Notes: counts are derived from times in ns
`ifndef HOST_PORT_PARAMS_SVH
`define HOST_PORT_PARAMS_SVH

`define BUS_W 8
`define MEM_DEPTH 256
`define CLK_PERIOD_NS 4
// shortest reset pulse that is accepted; shorter is a glitch
`define RST_FILT_NS 12
`define RST_FILT_CYC ((`RST_FILT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// release width of the interrupt pin, one internal write strobe
`define IRQ_PULSE_NS 20
`define IRQ_PULSE_CYC (`IRQ_PULSE_NS / `CLK_PERIOD_NS)
// interrupt register window
`define IRQ_REG_LO 8'h08
`define IRQ_REG_HI 8'h0B
`define SYNC_STAGES 2

`endif

// >>> src/host_port_pkg.sv
// Purpose: types of the multiplexed host bus port
// Assumes: nothing
// Notes: state codes are Gray along idle-read-write
package host_port_pkg;

  typedef enum logic [1:0] {
    OP_NONE = 2'h0,
    OP_READ = 2'h1,
    OP_WR_SEP = 2'h2,
    OP_WR_EN = 2'h3
  } op_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_READ = 2'h1,
    ST_WRITE = 2'h3
  } state_t;

endpackage

// >>> src/pin_sync.sv
// Purpose: two-flop synchroniser for asynchronous pins
// Assumes: inputs come from outside the ref_clk domain
// Notes: first stage is read only by the second stage
`timescale 1ns/10ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic ref_clk,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // two stages, no reset so no value is forced into the chain
  always_ff @(posedge ref_clk) begin
    meta_q <= async_in;
    sync_q <= meta_q;
  end

  assign sync_out = sync_q;

endmodule

// >>> src/muxed_host_bus_port.sv
// Purpose: 8-bit multiplexed host bus port with memory and irq pin
// Assumes: host pins are asynchronous to ref_clk
// Notes: internal registers and RAM are one 256-byte array
`timescale 1ns/10ps
`include "host_port_params.svh"
module muxed_host_bus_port (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic reset_pin,
  input wire logic [`BUS_W-1:0] addr_data_in,
  output logic [`BUS_W-1:0] addr_data_out,
  output logic [`BUS_W-1:0] addr_data_oe,
  input wire logic addr_latch,
  input wire logic read_cmd,
  input wire logic write_cmd,
  input wire logic chip_sel,
  output logic irq_n_out,
  output logic irq_n_oe,
  output logic clock_buffer_out,
  input wire logic int_pending,
  input wire logic int_cleared,
  input wire logic core_we,
  input wire logic [`BUS_W-1:0] core_addr,
  input wire logic [`BUS_W-1:0] core_wdata,
  output logic host_wr_strobe,
  output logic [`BUS_W-1:0] host_wr_addr,
  output logic [`BUS_W-1:0] host_wr_data,
  output logic int_reset
);

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [4:0] ctl_s;
  logic [`BUS_W-1:0] bus_s;
  logic ale_s, rd_s, wr_s, cs_s, rst_pin_s;

  pin_sync #(.WIDTH(5)) u_ctl_sync (
    .ref_clk(ref_clk),
    .async_in({reset_pin, chip_sel, write_cmd, read_cmd, addr_latch}),
    .sync_out(ctl_s)
  );

  pin_sync #(.WIDTH(`BUS_W)) u_bus_sync (
    .ref_clk(ref_clk),
    .async_in(addr_data_in),
    .sync_out(bus_s)
  );

  assign {rst_pin_s, cs_s, wr_s, rd_s, ale_s} = ctl_s;

  // ---------------------------------------------------------------
  // reset pin glitch filter
  // ---------------------------------------------------------------
  logic filt_d, filt_q;
  logic [1:0] fcnt_d, fcnt_q;
  logic rst_int;

  // level must stand for the filter time before it is taken
  always_comb begin
    filt_d = filt_q;
    fcnt_d = 2'h0;
    if (rst_pin_s != filt_q) begin
      if (fcnt_q == 2'(`RST_FILT_CYC - 1)) begin
        filt_d = rst_pin_s;
      end else begin
        fcnt_d = fcnt_q + 2'h1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      filt_q <= 1'b0;
      fcnt_q <= 2'h0;
    end else begin
      filt_q <= filt_d;
      fcnt_q <= fcnt_d;
    end
  end

  assign rst_int = sys_rst | filt_q;

  // ---------------------------------------------------------------
  // access decode and sequencing
  // ---------------------------------------------------------------
  host_port_pkg::op_t op;
  host_port_pkg::state_t state_d, state_q;
  logic ale_prev_q, ale_fall;
  logic [`BUS_W-1:0] addr_d, addr_q, wdata_d, wdata_q;
  logic [`BUS_W-1:0] rdata_d, rdata_q;
  logic oe_d, oe_q, wstb_d, wstb_q, acc_start, op_wr;
  logic [`BUS_W-1:0] mem_q [`MEM_DEPTH];

  assign ale_fall = ale_prev_q & ~ale_s;

  // pin decode; select may stay high, only the command matters
  // accesses are timed by command strobes or the enable strobe
  always_comb begin
    if (!cs_s) begin
      op = host_port_pkg::OP_NONE;
    end else begin
      unique case ({rd_s, wr_s})
        2'b00: op = host_port_pkg::OP_WR_EN;
        2'b01: op = host_port_pkg::OP_READ;
        2'b10: op = host_port_pkg::OP_WR_SEP;
        2'b11: op = host_port_pkg::OP_NONE;
      endcase
    end
  end

  assign op_wr = (op == host_port_pkg::OP_WR_EN) ||
                 (op == host_port_pkg::OP_WR_SEP);
  assign acc_start = (state_q == host_port_pkg::ST_IDLE) &&
                     (op != host_port_pkg::OP_NONE);

  // next state, address latch, read fetch and write commit
  always_comb begin
    state_d = state_q;
    addr_d = addr_q;
    wdata_d = wdata_q;
    rdata_d = rdata_q;
    oe_d = 1'b0;
    wstb_d = 1'b0;
    if (ale_fall) begin
      addr_d = bus_s;
    end
    unique case (state_q)
      host_port_pkg::ST_IDLE: begin
        if (op == host_port_pkg::OP_READ) begin
          rdata_d = mem_q[addr_q];
          state_d = host_port_pkg::ST_READ;
          oe_d = 1'b1;
        end else if (op_wr) begin
          wdata_d = bus_s;
          state_d = host_port_pkg::ST_WRITE;
        end
      end
      host_port_pkg::ST_READ: begin
        // drive data only while the read stands
        oe_d = (op == host_port_pkg::OP_READ);
        if (op != host_port_pkg::OP_READ) begin
          state_d = host_port_pkg::ST_IDLE;
        end
      end
      host_port_pkg::ST_WRITE: begin
        if (op_wr) begin
          wdata_d = bus_s;
        end else begin
          // commit once the synchronised strobe has ended
          wstb_d = 1'b1;
          state_d = host_port_pkg::ST_IDLE;
        end
      end
      default: state_d = host_port_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst_int) begin
      state_q <= host_port_pkg::ST_IDLE;
      ale_prev_q <= 1'b0;
      addr_q <= 8'h00;
      wdata_q <= 8'h00;
      rdata_q <= 8'h00;
      oe_q <= 1'b0;
      wstb_q <= 1'b0;
    end else begin
      state_q <= state_d;
      ale_prev_q <= ale_s;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      rdata_q <= rdata_d;
      oe_q <= oe_d;
      wstb_q <= wstb_d;
    end
  end

  // storage; host writes win over core writes
  always_ff @(posedge ref_clk) begin
    if (wstb_d) begin
      mem_q[addr_q] <= wdata_q;
    end else if (core_we) begin
      mem_q[core_addr] <= core_wdata;
    end
  end

  assign addr_data_out = rdata_q;
  assign addr_data_oe = {`BUS_W{oe_q}};
  assign host_wr_strobe = wstb_q;

  // host write notice registers
  logic [`BUS_W-1:0] wr_addr_q, wr_data_q;
  always_ff @(posedge ref_clk) begin
    if (rst_int) begin
      wr_addr_q <= 8'h00;
      wr_data_q <= 8'h00;
    end else if (wstb_d) begin
      wr_addr_q <= addr_q;
      wr_data_q <= wdata_q;
    end
  end
  assign host_wr_addr = wr_addr_q;
  assign host_wr_data = wr_data_q;

  // ---------------------------------------------------------------
  // interrupt pin and clock output
  // ---------------------------------------------------------------
  logic [2:0] rel_d, rel_q;
  logic irq_oe_d, irq_oe_q, ck_d, ck_q, irq_win;

  assign irq_win = (addr_q >= `IRQ_REG_LO) && (addr_q <= `IRQ_REG_HI);

  always_comb begin
    rel_d = rel_q;
    if (rel_q != 3'h0) begin
      rel_d = rel_q - 3'h1;
    end
    // clear with another pending releases the pin one strobe width
    if (int_cleared && int_pending) begin
      rel_d = 3'(`IRQ_PULSE_CYC);
    end
    // interrupt register access releases the pin
    if (acc_start && irq_win) begin
      rel_d = 3'(`IRQ_PULSE_CYC);
    end
    // pull low while an event is pending
    irq_oe_d = int_pending && (rel_d == 3'h0);
    ck_d = ~ck_q;
  end

  always_ff @(posedge ref_clk) begin
    if (rst_int) begin
      rel_q <= 3'h0;
      irq_oe_q <= 1'b0;
      ck_q <= 1'b0;
    end else begin
      rel_q <= rel_d;
      irq_oe_q <= irq_oe_d;
      ck_q <= ck_d;
    end
  end

  assign irq_n_out = 1'b0;
  assign irq_n_oe = irq_oe_q;
  assign clock_buffer_out = ck_q;
  assign int_reset = filt_q;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  sequence clr_seen_s;
    int_cleared && int_pending;
  endsequence

  sequence released_s;
    !irq_n_oe [*5];
  endsequence

  addr_capture_a: assert property (@(posedge ref_clk) disable iff (rst_int)
    ale_fall |=> (addr_q == $past(bus_s)))
    else $error("address not captured on latch fall");

  read_decode_a: assert property (@(posedge ref_clk) disable iff (rst_int)
    (state_q == host_port_pkg::ST_IDLE && cs_s && !rd_s && wr_s)
    |=> addr_data_oe[0] && addr_data_out == $past(mem_q[addr_q]))
    else $error("read decode did not drive fetched data");

  write_commit_a: assert property (@(posedge ref_clk) disable iff (rst_int)
    (state_q == host_port_pkg::ST_WRITE && !op_wr)
    |=> host_wr_strobe && host_wr_data == $past(wdata_q))
    else $error("write not committed at strobe end");

  data_quiet_a: assert property (@(posedge ref_clk) disable iff (rst_int)
    (op != host_port_pkg::OP_READ) |=> !addr_data_oe[0])
    else $error("data driven outside a read");

  irq_pulse_a: assert property (@(posedge ref_clk) disable iff (rst_int)
    clr_seen_s |=> released_s)
    else $error("irq pin not released for full pulse");

  rst_filter_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (!filt_q && rst_pin_s) [*3] |=> filt_q)
    else $error("reset pin not accepted after filter time");

  ck_stop_a: assert property (@(posedge ref_clk)
    rst_int |=> !clock_buffer_out)
    else $error("clock output toggled in reset");

  irq_assert_a: assert property (@(posedge ref_clk) disable iff (rst_int)
    (int_pending && rel_q == 3'h0 && !int_cleared && !acc_start)
    |=> irq_n_oe)
    else $error("pending event did not pull irq low");

  irq_window_a: assert property (@(posedge ref_clk) disable iff (rst_int)
    (acc_start && irq_win) |=> !irq_n_oe ##1 !irq_n_oe)
    else $error("irq register access did not release pin");

endmodule

// >>> test/host_mcu_model.sv
// Purpose: host microcontroller on the multiplexed bus
// Assumes: pins change just after ref_clk rising edges
// Notes: released lines show the inverse of the last access's data byte, driven or not
`timescale 1ns/10ps
module host_mcu_model (
  input wire logic ref_clk,
  input wire logic [7:0] addr_data_out,
  input wire logic [7:0] addr_data_oe,
  output logic [7:0] addr_data_in,
  output logic addr_latch,
  output logic read_cmd,
  output logic write_cmd,
  output logic chip_sel
);
  logic [7:0] drv_q;
  logic drv_en;
  assign addr_data_in = addr_data_oe[0] ? addr_data_out :
    (drv_en ? drv_q : ~drv_q);
  // idle pins at time zero
  initial begin
    drv_q = 8'h00;
    drv_en = 1'b0;
    addr_latch = 1'b0;
    read_cmd = 1'b1;
    write_cmd = 1'b1;
    chip_sel = 1'b0;
  end
  // one access in either strobe convention
  task automatic access(input logic en, input logic w, input logic k,
    input logic [7:0] a, input logic [7:0] d, output logic [7:0] q,
    output logic late);
    int i;
    @(posedge ref_clk);
    chip_sel <= chip_sel & ~en;
    read_cmd <= ~en;
    drv_q <= a;
    drv_en <= 1'b1;
    addr_latch <= 1'b1;
    repeat (3) @(posedge ref_clk);
    addr_latch <= 1'b0;
    repeat (3) @(posedge ref_clk);
    drv_q <= d;
    drv_en <= w;
    chip_sel <= 1'b1;
    write_cmd <= en ? ~w : ~w | ~w;
    if (!en && !w) read_cmd <= 1'b0;
    late = 1'b0;
    q = 8'h00;
    repeat (6) @(posedge ref_clk);
    for (i = 0; i < 20 && !w && addr_data_oe[0] !== 1'b1; i++) begin
      @(posedge ref_clk);
    end
    late = (i == 20);
    q = addr_data_out;
    chip_sel <= k & ~en;
    read_cmd <= ~en;
    write_cmd <= 1'b1;
    drv_en <= 1'b0;
    repeat (6) @(posedge ref_clk);
  endtask
  // raw pin levels for decode checks
  task automatic raw(input logic cs, input logic rd, input logic wr);
    @(posedge ref_clk);
    chip_sel <= cs;
    read_cmd <= rd;
    write_cmd <= wr;
    repeat (8) @(posedge ref_clk);
    chip_sel <= 1'b0;
    read_cmd <= 1'b1;
    write_cmd <= 1'b1;
    repeat (4) @(posedge ref_clk);
  endtask
endmodule

// >>> test/muxed_host_bus_port_tb_top.sv
// Purpose: self-checking bench of the multiplexed host bus port
// Assumes: host model drives the bus pins
// Notes: core write port is left idle
`timescale 1ns/10ps
module muxed_host_bus_port_tb_top;
  logic ref_clk, sys_rst, reset_pin, int_pending, int_cleared;
  logic [7:0] ad_in, ad_out, ad_oe, wr_a, wr_d, wr_cnt, low_cnt, oe_cnt, q;
  logic ale, rd, wr, cs, irq_o, irq_oe, ck_out, wr_stb, int_rst;
  int errors, checked;
  muxed_host_bus_port dut_u (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .reset_pin(reset_pin), .addr_data_in(ad_in), .addr_data_out(ad_out),
    .addr_data_oe(ad_oe), .addr_latch(ale), .read_cmd(rd),
    .write_cmd(wr), .chip_sel(cs), .irq_n_out(irq_o), .irq_n_oe(irq_oe),
    .clock_buffer_out(ck_out), .int_pending(int_pending),
    .int_cleared(int_cleared), .core_we(1'b0), .core_addr(8'h00),
    .core_wdata(8'h00), .host_wr_strobe(wr_stb), .host_wr_addr(wr_a),
    .host_wr_data(wr_d), .int_reset(int_rst));
  host_mcu_model host_u (.ref_clk(ref_clk), .addr_data_out(ad_out),
    .addr_data_oe(ad_oe), .addr_data_in(ad_in), .addr_latch(ale),
    .read_cmd(rd), .write_cmd(wr), .chip_sel(cs));
  // ----------------------------------------
  // clock and event counters
  // ----------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    if (wr_stb === 1'b1) wr_cnt <= wr_cnt + 8'h01;
    if (ad_oe[0] === 1'b1) oe_cnt <= oe_cnt + 8'h01;
    if (int_pending && irq_oe === 1'b0) low_cnt <= low_cnt + 8'h01;
  end
  task automatic chk(input string n, input logic [7:0] e,
    input logic [7:0] g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wrap_up;
    if (errors == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic acc(input logic en, input logic w, input logic k,
    input logic [7:0] a, input logic [7:0] d);
    logic late;
    host_u.access(en, w, k, a, d, q, late);
    if (late !== 1'b0) begin
      errors++;
      wrap_up();
    end
  endtask
  // separate strobes, select held high, back to back
  task automatic sep_write_read;
    logic [7:0] n;
    n = wr_cnt;
    acc(1'b0, 1'b1, 1'b1, 8'h40, 8'hA5);
    chk("write address", 8'h40, wr_a);
    chk("write data", 8'hA5, wr_d);
    acc(1'b0, 1'b1, 1'b1, 8'hFF, 8'h5A);
    chk("write count", n + 8'h02, wr_cnt);
    acc(1'b0, 1'b0, 1'b1, 8'h40, 8'h00);
    chk("read data", 8'hA5, q);
    acc(1'b0, 1'b0, 1'b0, 8'hFF, 8'h00);
    chk("read data", 8'h5A, q);
    chk("bus enable idle", 8'h00, ad_oe);
  endtask
  // enable strobe convention, then cross read
  task automatic enable_mode;
    acc(1'b1, 1'b1, 1'b0, 8'h80, 8'h3C);
    chk("write data", 8'h3C, wr_d);
    acc(1'b1, 1'b0, 1'b0, 8'h80, 8'h00);
    chk("read data", 8'h3C, q);
    acc(1'b0, 1'b0, 1'b1, 8'h80, 8'h00);
    chk("read data", 8'h3C, q);
  endtask
  // decodes that do nothing
  task automatic no_ops;
    logic [7:0] n, o;
    n = wr_cnt;
    o = oe_cnt;
    host_u.raw(1'b0, 1'b1, 1'b0);
    host_u.raw(1'b0, 1'b0, 1'b1);
    host_u.raw(1'b0, 1'b0, 1'b0);
    host_u.raw(1'b1, 1'b1, 1'b1);
    chk("write count", n, wr_cnt);
    chk("read enable count", o, oe_cnt);
  endtask
  // interrupt pin release on clear and on window access
  task automatic irq_release;
    logic [7:0] l;
    logic [7:0] a [4] = '{8'h07, 8'h08, 8'h0B, 8'h0C};
    logic [7:0] e [4] = '{8'h00, 8'h05, 8'h05, 8'h00};
    int_pending <= 1'b1;
    repeat (4) @(posedge ref_clk);
    chk("irq drive", 8'h01, 8'(irq_oe));
    chk("irq level", 8'h00, 8'(irq_o));
    l = low_cnt;
    int_cleared <= 1'b1;
    @(posedge ref_clk);
    int_cleared <= 1'b0;
    repeat (12) @(posedge ref_clk);
    chk("irq release", l + 8'h05, low_cnt);
    for (int i = 0; i < 4; i++) begin
      l = low_cnt;
      acc(1'b0, 1'b0, 1'b0, a[i], 8'h00);
      chk("irq release", l + e[i], low_cnt);
    end
    int_pending <= 1'b0;
    repeat (3) @(posedge ref_clk);
    chk("irq drive", 8'h00, 8'(irq_oe));
  endtask
  // reset pin glitch filter and clock output gating
  task automatic reset_pin_filter;
    logic c;
    @(posedge ref_clk);
    c = ck_out;
    @(posedge ref_clk);
    chk("clock out", {7'h00, ~c}, 8'(ck_out));
    reset_pin <= 1'b1;
    repeat (2) @(posedge ref_clk);
    reset_pin <= 1'b0;
    repeat (8) @(posedge ref_clk);
    chk("reset level", 8'h00, 8'(int_rst));
    reset_pin <= 1'b1;
    repeat (10) @(posedge ref_clk);
    chk("reset level", 8'h01, 8'(int_rst));
    chk("clock out", 8'h00, 8'(ck_out));
    reset_pin <= 1'b0;
    repeat (10) @(posedge ref_clk);
    chk("reset level", 8'h00, 8'(int_rst));
  endtask
  // main sequence
  initial begin
    errors = 0;
    checked = 0;
    wr_cnt = 8'h00;
    oe_cnt = 8'h00;
    low_cnt = 8'h00;
    sys_rst = 1'b1;
    reset_pin = 1'b0;
    int_pending = 1'b0;
    int_cleared = 1'b0;
    repeat (6) @(posedge ref_clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    sep_write_read();
    enable_mode();
    no_ops();
    irq_release();
    reset_pin_filter();
    wrap_up();
  end
  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge ref_clk);
    errors++;
    wrap_up();
  end
endmodule
